// >>> testbench/sensor_model.sv
// Purpose : sensor source walking a gray-coded three-pin pattern
// Assumes : pins reach the block through its synchroniser
// Notes   : skip jumps two places, a move the decoder calls illegal
`timescale 1ns/1ps
module sensor_model (
  input  wire logic       mclk,  // block clock
  input  wire logic       rst_n, // reset, active low
  input  wire logic       adv,   // move one place
  input  wire logic       skip,  // move two places
  output logic      [2:0] pins   // sensor levels
);
  logic [2:0] pos;
  logic [2:0] next_pos;
  always_comb
  begin
    next_pos = pos + {1'b0, skip, adv & ~skip};
  end
  always_ff @(posedge mclk)
  begin
    pos <= rst_n ? next_pos : 3'h0;
  end
  // gray code: one pin changes per legal place
  assign pins = pos ^ (pos >> 1);
endmodule : sensor_model

// >>> testbench/tb.sv
// Purpose : self-checking bench for the status and interrupt block
// Assumes : design answers reads one cycle after the select
// Notes   : reverse counter runs its full 16-bit range once
`timescale 1ns/1ps
module tb;
  logic        mclk, rst_n, reg_sel, reg_wr, bad_event, fwd_step;
  logic        rev_step, adv, skip, irq;
  logic [15:0] reg_wdata, reg_rdata, fmod, rmod, fcnt, rcnt, ctrl;
  logic [15:0] exp_st, exp_ct, d;
  logic [2:0]  pins, lvl, dstate;
  int          n_mismatch, check_count, m;

  sensor_model u_src (.mclk(mclk), .rst_n(rst_n), .adv(adv),
    .skip(skip), .pins(pins));
  event_status u_dut (.mclk(mclk), .rst_n(rst_n), .reg_sel(reg_sel),
    .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .sensor_inputs(pins), .sensor_level(lvl), .bad_event(bad_event),
    .decoder_state(dstate), .fwd_step(fwd_step), .rev_step(rev_step),
    .forward_modulus(fmod), .reverse_modulus(rmod),
    .forward_count(fcnt), .reverse_count(rcnt),
    .control_config(ctrl), .irq(irq));

  // ****************************************
  // bus tasks and checks
  // ****************************************
  task end_of_test;
    $display("mismatches %0d checks %0d", n_mismatch, check_count);
    if (n_mismatch == 0 && check_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : end_of_test
  task chk_word(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_word
  // irq trails its flag and enable by one edge, so let an edge pass first
  task chk_irq(input logic [15:0] e);
    @(posedge mclk);
    @(negedge mclk);
    chk_word({15'h0000, irq}, e);
  endtask : chk_irq
  function logic [15:0] exp_irq(input logic [15:0] s, input logic [15:0] c);
    return {15'h0000, |(s[2:0] & c[15:13])};
  endfunction : exp_irq
  task wr(input logic s, input logic [15:0] v);
    @(posedge mclk);
    reg_sel   <= s;
    reg_wr    <= 1'b1;
    reg_wdata <= v;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask : wr
  // reads settle a full cycle before the compare so irq is current too
  task rd(input logic s, input logic [15:0] e);
    @(posedge mclk);
    reg_sel <= s;
    repeat (2) @(posedge mclk);
    @(negedge mclk);
    chk_word(reg_rdata, e);
  endtask : rd
  task steps(input int n, input logic f);
    @(posedge mclk);
    fwd_step <= f;
    rev_step <= ~f;
    repeat (n) @(posedge mclk);
    fwd_step <= 1'b0;
    rev_step <= 1'b0;
    @(negedge mclk);
  endtask : steps

  initial
  begin
    forever #50 mclk = ~mclk;
  end
  initial
  begin
    repeat (100000) @(posedge mclk);
    n_mismatch++;
    end_of_test;
  end

  // ****************************************
  // main sequence
  // ****************************************
  initial
  begin
    {mclk, rst_n, reg_sel, reg_wr, bad_event, fwd_step} = '0;
    {rev_step, adv, skip, reg_wdata, dstate, fmod, rmod} = '0;
    void'($urandom(32'hf54e_916d));
    repeat (5) @(posedge mclk);
    rst_n <= 1'b1;
    rd(1'b0, 16'h0000);
    rd(1'b1, 16'h0000);
    d = 16'($urandom);
    d[7] = 1'b0;
    wr(1'b1, d);
    rd(1'b1, d);
    d[7] = 1'b1;
    wr(1'b1, d);
    exp_ct = d;
    d = 16'($urandom);
    wr(1'b1, d);
    exp_ct = (d & 16'hE080) | (exp_ct & 16'h1F7F);
    rd(1'b1, exp_ct);
    chk_word(ctrl, exp_ct);
    wr(1'b1, 16'h0000);
    rd(1'b1, exp_ct & 16'h1F7F);
    chk_word(ctrl, exp_ct & 16'h1F7F);
    wr(1'b1, 16'h0000);
    exp_ct = 16'h0000;
    m = 1 + $urandom_range(14);
    fmod <= m[15:0];
    steps(m, 1'b1);
    chk_word(fcnt, m[15:0]);
    steps(1, 1'b1);
    chk_word(fcnt, 16'h0000);
    exp_st = 16'h0001;
    rd(1'b0, exp_st);
    chk_irq(exp_irq(exp_st, exp_ct));
    wr(1'b1, 16'h2000);
    exp_ct = 16'h2000;
    chk_irq(exp_irq(exp_st, exp_ct));
    wr(1'b0, 16'h0000);
    rd(1'b0, exp_st);
    wr(1'b0, 16'h0001);
    exp_st = 16'h0000;
    rd(1'b0, exp_st);
    chk_irq(16'h0000);
    steps(65535, 1'b0);
    chk_word(rcnt, 16'hFFFF);
    steps(1, 1'b0);
    chk_word(rcnt, 16'h0000);
    exp_st = 16'h0002;
    wr(1'b1, 16'h4000);
    exp_ct = 16'h4000;
    rd(1'b0, exp_st);
    chk_irq(exp_irq(exp_st, exp_ct));
    wr(1'b0, 16'h0002);
    wr(1'b1, 16'h0000);
    exp_ct = 16'h0000;
    for (int i = 0; i < 2; i++)
    begin
      @(posedge mclk);
      adv  <= 1'b1;
      skip <= 1'b1;
      @(posedge mclk);
      adv  <= 1'b0;
      skip <= 1'b0;
      repeat (5) @(posedge mclk);
      @(negedge mclk);
      chk_word({13'h0000, lvl}, {13'h0000, pins});
      @(posedge mclk);
      bad_event <= 1'b1;
      dstate    <= 3'($urandom);
      @(posedge mclk);
      bad_event <= 1'b0;
      exp_st = {1'b0, pins, 1'b0, dstate, 8'h04};
      rd(1'b0, exp_st);
      chk_irq(exp_irq(exp_st, exp_ct));
      wr(1'b1, 16'h8000);
      exp_ct = 16'h8000;
    end
    wr(1'b0, 16'hFFF8);
    rd(1'b0, exp_st);
    wr(1'b0, 16'h0004);
    exp_st[2] = 1'b0;
    rd(1'b0, exp_st);
    chk_irq(16'h0000);
    end_of_test;
  end
endmodule : tb

// >>> verilog/event_status.sv
// Purpose : status flags, snapshots, wrap counters and interrupt request
// Assumes : decoder and filter share mclk and deliver one-cycle strobes
// Notes   : register port answers reads one cycle after the select
`timescale 1ns/1ps
module event_status (
  input  wire logic        mclk,            // block clock, 10 MHz
  input  wire logic        rst_n,           // synchronous reset, active low
  input  wire logic        reg_sel,         // 0 status, 1 control
  input  wire logic        reg_wr,          // write strobe, one cycle
  input  wire logic [15:0] reg_wdata,       // write data
  output logic      [15:0] reg_rdata,       // selected register, registered
  input  wire logic [2:0]  sensor_inputs,   // sensor pins, asynchronous
  output logic      [2:0]  sensor_level,    // synchronised sensor levels
  input  wire logic        bad_event,       // illegal transition strobe
  input  wire logic [2:0]  decoder_state,   // decoder state this cycle
  input  wire logic        fwd_step,        // forward count strobe
  input  wire logic        rev_step,        // reverse count strobe
  input  wire logic [15:0] forward_modulus, // forward wrap value, 0 = off
  input  wire logic [15:0] reverse_modulus, // reverse wrap value, 0 = off
  output logic      [15:0] forward_count,   // forward counter
  output logic      [15:0] reverse_count,   // reverse counter
  output logic      [15:0] control_config,  // control register
  output logic             irq              // interrupt request level
);
  // ********************************************************************
  // input synchroniser
  // ********************************************************************
  logic [2:0] sensor_now;

  sensor_sync #(.WIDTH(3)) u_sync (
    .mclk  (mclk),
    .rst_n (rst_n),
    .pin   (sensor_inputs),
    .level (sensor_now)
  );

  // ********************************************************************
  // state
  // ********************************************************************
  logic [2:0]  invalid_input_snapshot;
  logic [2:0]  invalid_state_snapshot;
  logic        bad_sequence_flag;
  logic        reverse_wrap_flag;
  logic        forward_wrap_flag;
  logic [2:0]  next_in_snap;
  logic [2:0]  next_st_snap;
  logic        next_bad;
  logic        next_rev;
  logic        next_fwd;
  logic [15:0] next_fcount;
  logic [15:0] next_rcount;
  logic [15:0] next_ctrl;
  logic [15:0] next_rdata;
  logic        next_irq;
  logic [15:0] fwd_limit;
  logic [15:0] rev_limit;
  logic        fwd_wrap;
  logic        rev_wrap;
  logic        wr_status;
  logic        wr_ctrl;
  logic        unit_enable;
  logic        bad_sequence_irq_enable;
  logic        reverse_wrap_irq_enable;
  logic        forward_wrap_irq_enable;
  logic [15:0] status_view;

  assign unit_enable = control_config[event_status_pkg::POS_UNIT_ENABLE];
  assign bad_sequence_irq_enable =
    control_config[event_status_pkg::POS_BAD_IE];
  assign reverse_wrap_irq_enable =
    control_config[event_status_pkg::POS_REV_IE];
  assign forward_wrap_irq_enable =
    control_config[event_status_pkg::POS_FWD_IE];

  always_comb
  begin
    wr_status = reg_wr && (reg_sel == event_status_pkg::SEL_STATUS);
    wr_ctrl   = reg_wr && (reg_sel == event_status_pkg::SEL_CONTROL);

    // zero modulus means the counter runs the full range
    fwd_limit = (forward_modulus == event_status_pkg::MOD_OFF) ?
                event_status_pkg::COUNT_FULL : forward_modulus;
    rev_limit = (reverse_modulus == event_status_pkg::MOD_OFF) ?
                event_status_pkg::COUNT_FULL : reverse_modulus;
    fwd_wrap  = fwd_step && (forward_count == fwd_limit);
    rev_wrap  = rev_step && (reverse_count == rev_limit);

    next_fcount = forward_count;
    if (fwd_wrap)
    begin
      next_fcount = event_status_pkg::COUNT_RESET;
    end
    else if (fwd_step)
    begin
      next_fcount = forward_count + 16'h0001;
    end
    next_rcount = reverse_count;
    if (rev_wrap)
    begin
      next_rcount = event_status_pkg::COUNT_RESET;
    end
    else if (rev_step)
    begin
      next_rcount = reverse_count + 16'h0001;
    end

    // set beats a same-cycle clear; a zero written leaves the flag
    next_bad = (bad_sequence_flag &
               ~(wr_status & reg_wdata[event_status_pkg::POS_BAD_FLAG]))
               | bad_event;
    next_rev = (reverse_wrap_flag &
               ~(wr_status & reg_wdata[event_status_pkg::POS_REV_FLAG]))
               | rev_wrap;
    next_fwd = (forward_wrap_flag &
               ~(wr_status & reg_wdata[event_status_pkg::POS_FWD_FLAG]))
               | fwd_wrap;

    // snapshots ignore writes; the latest event overwrites
    next_in_snap = bad_event ? sensor_now : invalid_input_snapshot;
    next_st_snap = bad_event ? decoder_state : invalid_state_snapshot;

    next_ctrl = control_config;
    if (wr_ctrl)
    begin
      next_ctrl = unit_enable ?
        ((control_config & ~event_status_pkg::CTRL_OPEN_MASK) |
         (reg_wdata & event_status_pkg::CTRL_OPEN_MASK)) :
        reg_wdata;
    end

    status_view = 16'h0000;
    status_view[event_status_pkg::POS_IN_SNAP +: 3] = invalid_input_snapshot;
    status_view[event_status_pkg::POS_ST_SNAP +: 3] = invalid_state_snapshot;
    status_view[event_status_pkg::POS_BAD_FLAG] = bad_sequence_flag;
    status_view[event_status_pkg::POS_REV_FLAG] = reverse_wrap_flag;
    status_view[event_status_pkg::POS_FWD_FLAG] = forward_wrap_flag;
    next_rdata = (reg_sel == event_status_pkg::SEL_STATUS) ?
                 status_view : control_config;

    // request needs no bus activity, only the counting clock
    next_irq = (bad_sequence_flag & bad_sequence_irq_enable)
             | (reverse_wrap_flag & reverse_wrap_irq_enable)
             | (forward_wrap_flag & forward_wrap_irq_enable);
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      invalid_input_snapshot <= 3'h0;
      invalid_state_snapshot <= 3'h0;
      bad_sequence_flag      <= 1'b0;
      reverse_wrap_flag      <= 1'b0;
      forward_wrap_flag      <= 1'b0;
      forward_count          <= event_status_pkg::COUNT_RESET;
      reverse_count          <= event_status_pkg::COUNT_RESET;
      control_config         <= event_status_pkg::CTRL_RESET;
      reg_rdata              <= 16'h0000;
      irq                    <= 1'b0;
      sensor_level           <= 3'h0;
    end
    else
    begin
      invalid_input_snapshot <= next_in_snap;
      invalid_state_snapshot <= next_st_snap;
      bad_sequence_flag      <= next_bad;
      reverse_wrap_flag      <= next_rev;
      forward_wrap_flag      <= next_fwd;
      forward_count          <= next_fcount;
      reverse_count          <= next_rcount;
      control_config         <= next_ctrl;
      reg_rdata              <= next_rdata;
      irq                    <= next_irq;
      sensor_level           <= sensor_now;
    end
  end

  // ********************************************************************
  // checks
  // ********************************************************************
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  snap_input_a: assert property (bad_event |=>
    invalid_input_snapshot == $past(sensor_now))
    else $error("input snapshot missed the event");
  snap_state_a: assert property (bad_event ##1 !bad_event |=>
    invalid_state_snapshot == $past(decoder_state, 2))
    else $error("state snapshot not held");
  bad_flag_a: assert property (bad_event |=> bad_sequence_flag)
    else $error("bad sequence flag not set");
  bad_clear_a: assert property (wr_status && reg_wdata[2] &&
    !bad_event |=> !bad_sequence_flag)
    else $error("bad sequence flag not cleared");
  rev_wrap_a: assert property (
    rev_step && reverse_count == 16'hFFFF &&
    reverse_modulus == 16'h0000 |=>
    reverse_count == 16'h0000 && reverse_wrap_flag)
    else $error("reverse full range wrap wrong");
  fwd_wrap_a: assert property (
    fwd_step && forward_modulus != 16'h0000 &&
    forward_count == forward_modulus |=>
    forward_count == 16'h0000 && forward_wrap_flag)
    else $error("forward modulus wrap wrong");
  flag_keep_a: assert property (forward_wrap_flag && wr_status &&
    !reg_wdata[0] |=> forward_wrap_flag)
    else $error("zero write cleared a flag");
  irq_level_a: assert property (##1 irq ==
    $past(|({bad_sequence_flag, reverse_wrap_flag, forward_wrap_flag} &
    control_config[15:13])))
    else $error("request does not follow flags and enables");
  reserved_a: assert property (reg_sel == 1'b0 |=>
    (reg_rdata & event_status_pkg::STATUS_RSVD) == 16'h0000)
    else $error("reserved status bits not zero");
  ctrl_lock_a: assert property (wr_ctrl && unit_enable |=>
    control_config[12:8] == $past(control_config[12:8]) &&
    control_config[15:13] == $past(reg_wdata[15:13]))
    else $error("control lock wrong");

  bad_irq_c: cover property (bad_event ##1 bad_sequence_flag ##1 irq);
  fwd_wrap_c: cover property (fwd_wrap ##2 irq);
  set_clear_c: cover property (wr_status && reg_wdata[1] && rev_wrap);
endmodule : event_status

// >>> verilog/event_status_pkg.sv
// Purpose : constants for the position counter status and interrupt block
// Assumes : one clock, mclk at 10 MHz; 16-bit registers
// Notes   : register select codes are the index on reg_sel
//
// Contract
// - each bad-sequence event stores the three sensor levels in status 14:12.
// - each bad-sequence event stores the decoder state in status 10:8.
// - illegal transition sets status bit 2; writing one clears it.
// - reverse counter wraps at modulus or FFFF to zero, sets status bit 1.
// - forward counter wraps at modulus or FFFF to zero, sets status bit 0.
// - bad-sequence flag always set; interrupt only when control bit 15 set.
// - reverse wrap interrupts only when control bit 14 set; flag always.
// - forward wrap interrupts only when control bit 13 set; flag always.
// - while enabled, only status, the three enables and unit enable bit 7 stay writable.
// - modulus zero disables the modulus; counter uses full 16-bit range.
// - enabled sources raise the request while only the counting clock runs.
package event_status_pkg;
  localparam logic       SEL_STATUS      = 1'b0;
  localparam logic       SEL_CONTROL     = 1'b1;
  localparam int         POS_IN_SNAP     = 12;
  localparam int         POS_ST_SNAP     = 8;
  localparam int         POS_BAD_FLAG    = 2;
  localparam int         POS_REV_FLAG    = 1;
  localparam int         POS_FWD_FLAG    = 0;
  localparam int         POS_BAD_IE      = 15;
  localparam int         POS_REV_IE      = 14;
  localparam int         POS_FWD_IE      = 13;
  localparam int         POS_UNIT_ENABLE = 7;
  localparam logic [15:0] STATUS_RSVD    = 16'h88F8;
  localparam logic [15:0] CTRL_OPEN_MASK = 16'hE080;
  localparam logic [15:0] CTRL_RESET     = 16'h0000;
  localparam logic [15:0] COUNT_RESET    = 16'h0000;
  localparam logic [15:0] COUNT_FULL     = 16'hFFFF;
  localparam logic [15:0] MOD_OFF        = 16'h0000;
endpackage : event_status_pkg

// >>> verilog/sensor_sync.sv
// Purpose : three-stage synchroniser for the sensor input pins
// Assumes : pins are asynchronous to mclk
// Notes   : output changes only when stages two and three agree
`timescale 1ns/1ps
module sensor_sync #(
  parameter int WIDTH = 3
) (
  input  wire logic             mclk,   // block clock
  input  wire logic             rst_n,  // synchronous reset, active low
  input  wire logic [WIDTH-1:0] pin,    // raw pin levels
  output logic      [WIDTH-1:0] level   // settled levels
);
  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] stage2;
  logic [WIDTH-1:0] stage3;
  logic [WIDTH-1:0] next_level;

  genvar i;
  generate
    for (i = 0; i < WIDTH; i++)
    begin : g_bit
      // stage1 feeds stage2 only, so metastability never reaches a gate
      always_comb
      begin
        next_level[i] = (stage2[i] == stage3[i]) ? stage3[i] : level[i];
      end
    end
  endgenerate

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      stage1 <= '0;
      stage2 <= '0;
      stage3 <= '0;
      level  <= '0;
    end
    else
    begin
      stage1 <= pin;
      stage2 <= stage1;
      stage3 <= stage2;
      level  <= next_level;
    end
  end
endmodule : sensor_sync
